// *** nested_irq_consts.svh ***
/*
 constants for the nested interrupt controller: widths, positions, vectors, reset values.
 assumes inclusion by bare name from the package and modules.
*/
`ifndef NESTED_IRQ_CONSTS_SVH
`define NESTED_IRQ_CONSTS_SVH
// ==========================================
// widths
`define IRQ_COUNT 10
`define ADDR_WIDTH 32
// ==========================================
// source bit positions, equal to priority
`define SRC_SYNC 0
`define SRC_SW_EXC 1
`define SRC_MEM_FAULT 2
`define SRC_TIMER0 3
`define SRC_TIMER1 4
`define SRC_MESSAGE 5
`define SRC_DMA0 6
`define SRC_DMA1 7
`define SRC_WAND 8
`define SRC_USER 9
// ==========================================
// vector table
`define VECTOR_BASE 32'h0000_0000
`define VECTOR_STRIDE_SHIFT 2
// ==========================================
// status register field and reset values
`define STATUS_GID_BIT 1
`define LATCH_RESET 10'h000
`define MASK_RESET 10'h000
`define IN_SERVICE_RESET 10'h000
`define RETURN_RESET 32'h0000_0000
`define GID_RESET 1'b1
`endif

// *** nested_irq_pkg.sv ***
/*
 types for the nested interrupt controller.
 assumes nested_irq_consts.svh is on the include path.
*/
`include "nested_irq_consts.svh"
package nested_irq_pkg;
  typedef logic [`IRQ_COUNT-1:0] irq_vec_t;
  typedef logic [`ADDR_WIDTH-1:0] addr_t;
  // special-register selector for moves to and from the controller
  typedef enum logic [2:0] {
    sreg_latch = 3'h0,
    sreg_latch_set = 3'h1,
    sreg_latch_clear = 3'h2,
    sreg_masks = 3'h3,
    sreg_in_service = 3'h4,
    sreg_return = 3'h5,
    sreg_none = 3'h7
  } sreg_sel_t;
  // controller sequencing
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_enter = 3'b010,
    st_leave = 3'b100
  } ctl_state_t;
endpackage

// *** irq_edge_detect.sv ***
/*
 rising edge detector for a vector of event sources.
 assumes sources are synchronous to clk_sys.
*/
`timescale 1ns/1ps
module irq_edge_detect #(
  parameter int WIDTH = 10
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);
  logic [WIDTH-1:0] level_q;

  initial begin
    if (WIDTH < 1) begin
      $error("irq_edge_detect: WIDTH must be at least 1");
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      level_q <= '0;
    end else begin
      level_q <= level;
    end
  end

  // history starts low, so a source already high at reset release latches on the first edge after it
  assign rise = level & ~level_q;
endmodule

// *** core_nested_interrupt_controller.sv ***
/*
 per-core prioritized nested interrupt controller: latch, masks, in-service flags,
 return address, global disable flag and program-counter redirection.
 assumes the pipeline pulses its instruction strobes for one cycle, honours take_irq
 and return_taken within the same cycle, and drives special-register moves synchronously.
*/
`timescale 1ns/1ps
`include "nested_irq_consts.svh"

module core_nested_interrupt_controller #(
  parameter int IRQ_COUNT = `IRQ_COUNT,
  parameter int ADDR_WIDTH = `ADDR_WIDTH
) (
  input wire logic clk_sys,
  input wire logic rstn,
  // event sources
  input wire logic sync_signal,
  input wire logic fp_exception,
  input wire logic invalid_instr,
  input wire logic alignment_error,
  input wire logic mem_protect_fault,
  input wire logic timer0_expired,
  input wire logic timer1_expired,
  input wire logic message_event,
  input wire logic dma0_done,
  input wire logic dma1_done,
  input wire logic wand_signal,
  // instruction strobes from the pipeline
  input wire logic global_disable_instr,
  input wire logic global_enable_instr,
  input wire logic return_from_handler,
  input wire logic sync_instr,
  input wire logic remote_load_pending,
  input wire logic [ADDR_WIDTH-1:0] next_pc,
  // special-register moves
  input wire logic sreg_write,
  input wire nested_irq_pkg::sreg_sel_t sreg_sel,
  input wire logic [ADDR_WIDTH-1:0] sreg_wdata,
  output logic [ADDR_WIDTH-1:0] sreg_rdata,
  // program flow
  output logic take_irq,
  output logic return_taken,
  output logic [ADDR_WIDTH-1:0] redirect_pc,
  output logic global_disable,
  output logic sync_group_out,
  output logic [IRQ_COUNT-1:0] interrupt_latch,
  output logic [IRQ_COUNT-1:0] interrupt_masks,
  output logic [IRQ_COUNT-1:0] in_service_flags,
  output logic [ADDR_WIDTH-1:0] return_address
);
  import nested_irq_pkg::*;

  // ==========================================
  // elaboration checks
  initial begin
    if (IRQ_COUNT != `IRQ_COUNT) begin
      $error("core_nested_interrupt_controller: IRQ_COUNT must be 10");
    end
    if (ADDR_WIDTH != `ADDR_WIDTH) begin
      $error("core_nested_interrupt_controller: ADDR_WIDTH must be 32");
    end
    // the index helpers return four bits, so a wider latch would alias vectors
    if (IRQ_COUNT > 15) begin
      $error("core_nested_interrupt_controller: IRQ_COUNT exceeds the index width");
    end
    // bit 0 is forced by the sync instruction and the top bit is software only
    if (`SRC_SYNC != 0 || `SRC_USER != IRQ_COUNT - 1) begin
      $error("core_nested_interrupt_controller: source map does not span the latch");
    end
    // four bytes per entry hold exactly one 32-bit relative branch
    if (`VECTOR_STRIDE_SHIFT != 2) begin
      $error("core_nested_interrupt_controller: vector entries must be four bytes apart");
    end
    // the highest vector must be reachable through redirect_pc
    if (ADDR_WIDTH < 6) begin
      $error("core_nested_interrupt_controller: ADDR_WIDTH too small for the vector table");
    end
  end

  // ==========================================
  // helpers
  // lowest set bit index, which is the highest priority
  function automatic logic [3:0] top_index(input logic [IRQ_COUNT-1:0] v);
    logic [3:0] idx;
    idx = 4'hf;
    for (int i = IRQ_COUNT - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  // one-hot of the lowest set bit
  function automatic logic [IRQ_COUNT-1:0] top_onehot(input logic [IRQ_COUNT-1:0] v);
    return v & (~v + 1'b1);
  endfunction

  // write strobe for one special register; one decode serves every write path
  function automatic logic sreg_hit(input logic wr, input sreg_sel_t sel, input sreg_sel_t target);
    return wr && (sel == target);
  endfunction

  // mask of all bits strictly below the lowest set bit (higher priorities)
  function automatic logic [IRQ_COUNT-1:0] above_mask(input logic [IRQ_COUNT-1:0] v);
    logic [IRQ_COUNT-1:0] oh;
    oh = top_onehot(v);
    return (v == '0) ? '1 : (oh - 1'b1);
  endfunction

  // ==========================================
  // source edges
  logic [IRQ_COUNT-1:0] src_level;
  logic [IRQ_COUNT-1:0] src_rise;

  always_comb begin
    src_level = '0;
    src_level[`SRC_SYNC] = sync_signal;
    src_level[`SRC_SW_EXC] = fp_exception | invalid_instr | alignment_error;
    src_level[`SRC_MEM_FAULT] = mem_protect_fault;
    src_level[`SRC_TIMER0] = timer0_expired;
    src_level[`SRC_TIMER1] = timer1_expired;
    src_level[`SRC_MESSAGE] = message_event;
    src_level[`SRC_DMA0] = dma0_done;
    src_level[`SRC_DMA1] = dma1_done;
    src_level[`SRC_WAND] = wand_signal;
    src_level[`SRC_USER] = 1'b0;
  end

  irq_edge_detect #(
    .WIDTH(IRQ_COUNT)
  ) u_edges (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .level(src_level),
    .rise(src_rise)
  );

  // ==========================================
  // selection
  logic [IRQ_COUNT-1:0] eligible;
  logic [IRQ_COUNT-1:0] chosen;
  logic [3:0] chosen_idx;
  logic [IRQ_COUNT-1:0] top_service;
  logic can_take;
  logic wr_latch;
  logic wr_set;
  logic wr_clear;
  logic wr_masks;
  logic wr_return;

  assign wr_latch = sreg_hit(sreg_write, sreg_sel, sreg_latch);
  assign wr_set = sreg_hit(sreg_write, sreg_sel, sreg_latch_set);
  assign wr_clear = sreg_hit(sreg_write, sreg_sel, sreg_latch_clear);
  assign wr_masks = sreg_hit(sreg_write, sreg_sel, sreg_masks);
  assign wr_return = sreg_hit(sreg_write, sreg_sel, sreg_return);

  // only priorities above every active level, unmasked
  assign eligible = interrupt_latch & ~interrupt_masks & above_mask(in_service_flags);
  assign chosen = top_onehot(eligible);
  assign chosen_idx = top_index(eligible);
  assign top_service = top_onehot(in_service_flags);

  // a pending remote load stalls entry; the latch keeps the event meanwhile
  assign can_take = (eligible != '0) && !global_disable && !remote_load_pending
    && !return_from_handler;

  // ==========================================
  // handshake outputs
  always_comb begin
    take_irq = can_take;
    return_taken = return_from_handler;
  end

  // ==========================================
  // redirect address
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      redirect_pc <= `RETURN_RESET;
    end else if (can_take) begin
      redirect_pc <= `VECTOR_BASE + (ADDR_WIDTH'(chosen_idx) << `VECTOR_STRIDE_SHIFT);
    end else if (return_from_handler) begin
      redirect_pc <= return_address;
    end
  end

  // ==========================================
  // interrupt latch
  logic [IRQ_COUNT-1:0] next_latch;

  always_comb begin
    next_latch = interrupt_latch;
    if (wr_latch) begin
      next_latch = sreg_wdata[IRQ_COUNT-1:0];
    end
    if (wr_clear) begin
      next_latch = next_latch & ~sreg_wdata[IRQ_COUNT-1:0];
    end
    if (can_take) begin
      next_latch = next_latch & ~chosen;
    end
    if (wr_set) begin
      next_latch = next_latch | sreg_wdata[IRQ_COUNT-1:0];
    end
    // new edges win over any clear in the same cycle
    next_latch = next_latch | src_rise;
    if (sync_instr) begin
      next_latch[`SRC_SYNC] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      interrupt_latch <= `LATCH_RESET;
    end else begin
      interrupt_latch <= next_latch;
    end
  end

  // the group broadcast lets the sync fabric raise bit 0 on the other cores
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sync_group_out <= 1'b0;
    end else begin
      sync_group_out <= sync_instr;
    end
  end

  // ==========================================
  // masks
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      interrupt_masks <= `MASK_RESET;
    end else if (wr_masks) begin
      interrupt_masks <= sreg_wdata[IRQ_COUNT-1:0];
    end
  end

  // ==========================================
  // in-service flags
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      in_service_flags <= `IN_SERVICE_RESET;
    end else if (can_take) begin
      in_service_flags <= in_service_flags | chosen;
    end else if (return_from_handler) begin
      in_service_flags <= in_service_flags & ~top_service;
    end
  end

  // ==========================================
  // return address
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      return_address <= `RETURN_RESET;
    end else if (can_take) begin
      return_address <= next_pc;
    end else if (wr_return) begin
      return_address <= sreg_wdata;
    end
  end

  // ==========================================
  // global disable flag
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      global_disable <= `GID_RESET;
    end else if (can_take || global_disable_instr) begin
      global_disable <= 1'b1;
    end else if (global_enable_instr || return_from_handler) begin
      global_disable <= 1'b0;
    end
  end

  // ==========================================
  // special-register reads
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sreg_rdata <= '0;
    end else begin
      unique case (sreg_sel)
        sreg_latch: sreg_rdata <= ADDR_WIDTH'(interrupt_latch);
        sreg_masks: sreg_rdata <= ADDR_WIDTH'(interrupt_masks);
        sreg_in_service: sreg_rdata <= ADDR_WIDTH'(in_service_flags);
        sreg_return: sreg_rdata <= return_address;
        default: sreg_rdata <= '0;
      endcase
    end
  end
endmodule

// *** nic_pipe_model.sv ***
/* pipeline and event source model for the interrupt controller bench.
 assumes fire pulses come from the bench just after rising edges. */
`timescale 1ns/1ps
module nic_pipe_model (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [10:0] fire,
  output logic [10:0] src,
  output logic [31:0] next_pc
);
  logic [10:0] prev;
  // ==========
  // sources
  // each source stays high two cycles, so a held level must not latch twice
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      prev <= '0;
      src <= '0;
      next_pc <= 32'h0000_1000;
    end else begin
      prev <= fire;
      src <= fire | prev;
      next_pc <= next_pc + 32'h4;
    end
  end
endmodule

// *** core_nested_interrupt_controller_asserts.sv ***
/* port checker for the nested interrupt controller.
 assumes it is bound to every core_nested_interrupt_controller. */
`timescale 1ns/1ps
module nic_asserts #(
  parameter int IRQ_COUNT = 10,
  parameter int ADDR_WIDTH = 32
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic global_disable_instr,
  input wire logic return_from_handler,
  input wire logic sync_instr,
  input wire logic remote_load_pending,
  input wire logic [ADDR_WIDTH-1:0] next_pc,
  input wire logic take_irq,
  input wire logic [ADDR_WIDTH-1:0] redirect_pc,
  input wire logic global_disable,
  input wire logic sync_group_out,
  input wire logic [IRQ_COUNT-1:0] interrupt_latch,
  input wire logic [IRQ_COUNT-1:0] interrupt_masks,
  input wire logic [IRQ_COUNT-1:0] in_service_flags,
  input wire logic [ADDR_WIDTH-1:0] return_address
);
  logic [IRQ_COUNT-1:0] hit;
  // ==========
  // properties
  assign hit = IRQ_COUNT'(1) << redirect_pc[5:2];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  property p_gd; global_disable |-> !take_irq; endproperty
  a_gd: assert property (p_gd) else $error("entry while disabled");
  property p_load; remote_load_pending |-> !take_irq; endproperty
  a_load: assert property (p_load) else $error("entry during load");
  property p_enter; take_irq |=> global_disable && return_address == $past(next_pc)
    && hit == (in_service_flags & ~$past(in_service_flags)); endproperty
  a_enter: assert property (p_enter) else $error("bad entry");
  property p_vec; take_irq |=> redirect_pc[1:0] == 2'h0 && (redirect_pc >> 2) < IRQ_COUNT; endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_prio; take_irq |=> ($past(interrupt_latch & ~interrupt_masks) & (hit - 1'b1)) == 0; endproperty
  a_prio: assert property (p_prio) else $error("not highest");
  property p_nest; take_irq |=> ($past(in_service_flags) & ((hit << 1) - 1'b1)) == 0; endproperty
  a_nest: assert property (p_nest) else $error("entry not above service");
  property p_ret; return_from_handler && !global_disable_instr |=> !global_disable
    && redirect_pc == $past(return_address)
    && in_service_flags == ($past(in_service_flags) & ($past(in_service_flags) - 1'b1)); endproperty
  a_ret: assert property (p_ret) else $error("bad return");
  property p_dis; global_disable_instr |=> global_disable; endproperty
  a_dis: assert property (p_dis) else $error("disable lost");
  property p_sync; sync_instr |=> sync_group_out && interrupt_latch[0]; endproperty
  a_sync: assert property (p_sync) else $error("sync lost");
  c_take: cover property (take_irq);
  c_nest: cover property (take_irq && in_service_flags != 0);
  c_ret: cover property (return_from_handler);
endmodule
bind core_nested_interrupt_controller nic_asserts #(.IRQ_COUNT(IRQ_COUNT), .ADDR_WIDTH(ADDR_WIDTH)) u_chk (
  .clk_sys(clk_sys), .rstn(rstn), .global_disable_instr(global_disable_instr),
  .return_from_handler(return_from_handler), .sync_instr(sync_instr),
  .remote_load_pending(remote_load_pending), .next_pc(next_pc), .take_irq(take_irq),
  .redirect_pc(redirect_pc), .global_disable(global_disable), .sync_group_out(sync_group_out),
  .interrupt_latch(interrupt_latch), .interrupt_masks(interrupt_masks),
  .in_service_flags(in_service_flags), .return_address(return_address));

// *** test_core_nested_interrupt_controller.sv ***
/* self-checking bench for the nested interrupt controller.
 assumes nic_pipe_model drives sources and next_pc. */
`timescale 1ns/1ps
module test_core_nested_interrupt_controller;
  import nested_irq_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic dis = 1'b0, ena = 1'b0, ret = 1'b0, syn = 1'b0, rlp = 1'b0, sw = 1'b0;
  logic [10:0] fire = '0;
  logic [10:0] src;
  sreg_sel_t sel = sreg_none;
  logic [31:0] wd = '0, next_pc, rd, rpc, ra, pc, pc2;
  logic take, rt, gd, sgo;
  logic [9:0] lat, msk, isv;
  int errors = 0, comparisons = 0;
  // each row: source fire bits [14:4] beside the expected priority [3:0]
  logic [14:0] rows [11] = '{15'h0010, 15'h0021, 15'h0041, 15'h0081, 15'h0102, 15'h0203,
    15'h0404, 15'h0805, 15'h1006, 15'h2007, 15'h4008};
  always #10 clk_sys = ~clk_sys;
  nic_pipe_model pm (.clk_sys(clk_sys), .rstn(rstn), .fire(fire), .src(src), .next_pc(next_pc));
  core_nested_interrupt_controller dut (.clk_sys(clk_sys), .rstn(rstn), .sync_signal(src[0]),
    .fp_exception(src[1]), .invalid_instr(src[2]), .alignment_error(src[3]), .mem_protect_fault(src[4]),
    .timer0_expired(src[5]), .timer1_expired(src[6]), .message_event(src[7]), .dma0_done(src[8]),
    .dma1_done(src[9]), .wand_signal(src[10]), .global_disable_instr(dis), .global_enable_instr(ena),
    .return_from_handler(ret), .sync_instr(syn), .remote_load_pending(rlp), .next_pc(next_pc),
    .sreg_write(sw), .sreg_sel(sel), .sreg_wdata(wd), .sreg_rdata(rd), .take_irq(take), .return_taken(rt),
    .redirect_pc(rpc), .global_disable(gd), .sync_group_out(sgo), .interrupt_latch(lat),
    .interrupt_masks(msk), .in_service_flags(isv), .return_address(ra));
  // ==========
  // tasks
  task automatic stop_test;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic fire_src(input logic [10:0] f);
    @(posedge clk_sys);
    fire <= f;
    @(posedge clk_sys);
    fire <= '0;
  endtask
  task automatic op(input logic [2:0] v);
    @(posedge clk_sys);
    {dis, ena, syn} <= v;
    @(posedge clk_sys);
    {dis, ena, syn} <= 3'h0;
  endtask
  task automatic wr(input sreg_sel_t s, input logic [31:0] d);
    @(posedge clk_sys);
    sw <= 1'b1;
    sel <= s;
    wd <= d;
    @(posedge clk_sys);
    sw <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      chk(take, 0, "unexpected entry");
    end
  endtask
  // an entry can already stand in the cycle a return completes, so a caller at a falling edge looks at once
  task automatic enter(input int i);
    if (clk_sys) @(negedge clk_sys);
    for (int n = 0; n < 20 && take !== 1'b1; n++) @(negedge clk_sys);
    chk(take, 1, "no entry");
    if (take !== 1'b1) stop_test();
    pc = next_pc;
    @(negedge clk_sys);
    chk(rpc, 32'(i * 4), "vector");
    chk(isv[i], 1, "in service");
    chk(ra, pc, "saved return");
    chk(gd, 1, "entry disables");
  endtask
  task automatic leave(input logic [31:0] p, input logic [9:0] s);
    @(posedge clk_sys);
    ret <= 1'b1;
    @(negedge clk_sys);
    chk(rt, 1, "return taken");
    @(posedge clk_sys);
    ret <= 1'b0;
    @(negedge clk_sys);
    chk(rpc, p, "return pc");
    chk(isv, s, "return service");
    chk(gd, 0, "return enables");
  endtask
  // ==========
  // sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    @(negedge clk_sys);
    chk({lat, msk, isv}, 0, "reset regs");
    chk(ra, 0, "reset return");
    chk(gd, 1, "reset disable");
    fire_src(11'h020);
    idle(4);
    chk(lat, 10'h008, "held latch");
    op(3'h2);
    enter(3);
    leave(pc, 10'h000);
    $display("done reset");
    for (int k = 0; k < 11; k++) begin
      fire_src(rows[k][14:4]);
      enter(rows[k][3:0]);
      chk(lat, 0, "latch cleared");
      leave(pc, 10'h000);
      idle(2);
    end
    $display("done sources");
    wr(sreg_masks, 32'h8);
    fire_src(11'h020);
    idle(6);
    chk(lat, 10'h008, "masked held");
    chk(rd, 32'h8, "mask read");
    fire_src(11'h100);
    enter(6);
    leave(pc, 10'h000);
    wr(sreg_masks, 32'h0);
    enter(3);
    leave(pc, 10'h000);
    $display("done masks");
    op(3'h4);
    wr(sreg_latch_set, 32'h288);
    wr(sreg_latch_clear, 32'h208);
    @(negedge clk_sys);
    chk(lat, 10'h080, "set clear");
    wr(sreg_latch_set, 32'h8);
    op(3'h2);
    enter(3);
    leave(pc, 10'h000);
    enter(7);
    pc2 = pc;
    op(3'h2);
    wr(sreg_latch_set, 32'h108);
    enter(3);
    chk(isv, 10'h088, "nested");
    leave(pc, 10'h080);
    idle(4);
    // the nested entry overwrote the saved address; the handler restores it as software would
    wr(sreg_return, pc2);
    repeat (2) @(negedge clk_sys);
    chk(rd, pc2, "return read");
    leave(pc2, 10'h000);
    enter(8);
    leave(pc, 10'h000);
    wr(sreg_latch_set, 32'h200);
    enter(9);
    leave(pc, 10'h000);
    $display("done nesting");
    op(3'h1);
    @(negedge clk_sys);
    chk(sgo, 1, "sync broadcast");
    enter(0);
    leave(pc, 10'h000);
    @(posedge clk_sys);
    rlp <= 1'b1;
    fire_src(11'h040);
    idle(6);
    @(posedge clk_sys);
    rlp <= 1'b0;
    enter(4);
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(negedge clk_sys);
    chk({gd, isv, lat}, 32'h0010_0000, "second reset");
    $display("done load and reset");
    stop_test();
  end
endmodule
